// ---- hdl/mbrs_map.svh ----
// Register offsets, field positions, opcodes, reset values and timing counts
`ifndef MBRS_MAP_SVH
`define MBRS_MAP_SVH

// Register byte offsets
`define MBRS_OFF_CTRL 8'h00
`define MBRS_OFF_STATUS 8'h04
`define MBRS_OFF_WREG 8'h08
`define MBRS_OFF_BANK 8'h0C
`define MBRS_OFF_PC 8'h10
`define MBRS_OFF_TOS 8'h14
`define MBRS_OFF_WDT 8'h18
`define MBRS_OFF_STKPTR 8'h1C

// Control fields
`define MBRS_CTRL_RUN 0
`define MBRS_CTRL_WDT_EN 1

// Status fields; flags share these positions inside the flag vector
`define MBRS_FLAG_C 0
`define MBRS_FLAG_DC 1
`define MBRS_FLAG_Z 2
`define MBRS_FLAG_OV 3
`define MBRS_FLAG_N 4
`define MBRS_FLAG_MSB 4
`define MBRS_STAT_PD_N 8
`define MBRS_STAT_TO_N 9
`define MBRS_STAT_SLEEP 10
`define MBRS_STAT_STK_FULL 11

// Instruction encodings
`define MBRS_OPC_BRANCH_CARRY 8'hE2
`define MBRS_OPC_REL_CALL 5'h1B
`define MBRS_OPC_ROT_LEFT 6'h11
`define MBRS_OPC_ROT_RIGHT 6'h0C
`define MBRS_OPC_SUB_BORROW 6'h15
`define MBRS_INSN_RESET 16'h00FF
`define MBRS_INSN_SLEEP 16'h0003
`define MBRS_INSN_NOP 16'h0000

// Access bank halves
`define MBRS_ACCESS_LOW_BANK 4'h0
`define MBRS_ACCESS_HIGH_BANK 4'hF

// Reset values
`define MBRS_RST_RUN 1'b1
`define MBRS_RST_WDT_EN 1'b0
`define MBRS_RST_PC 21'h00_0000
`define MBRS_RST_WREG 8'h00
`define MBRS_RST_BANK 4'h0
`define MBRS_RST_FLAGS 5'h00
`define MBRS_RST_WDT 8'h00

// Sizes and timing counts
`define MBRS_STACK_DEPTH 31
`define MBRS_WDT_POST 128
`define MBRS_PC_STEP 21'h00_0002

`endif

// ---- hdl/mbrs_pkg.sv ----
// Types shared by the execution unit
package mbrs_pkg;

   typedef enum logic [1:0] {MBRS_Q1, MBRS_Q2, MBRS_Q3, MBRS_Q4} mbrs_quarter_t;

   typedef enum logic [2:0] {
      MBRS_OP_NOP,
      MBRS_OP_BRANCH_IF_CARRY,
      MBRS_OP_REL_SUB_CALL,
      MBRS_OP_SOFT_RESET,
      MBRS_OP_SLEEP,
      MBRS_OP_ROTATE_LEFT_NO_CARRY,
      MBRS_OP_ROTATE_RIGHT_THRU_CARRY,
      MBRS_OP_SUB_F_FROM_W_BORROW
   } mbrs_op_t;

endpackage : mbrs_pkg

// ---- hdl/mbrs_exec.sv ----
// Execution unit for carry branch, relative call, rotates, borrow subtract, reset, sleep
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mbrs_map.svh"
module mbrs_exec
   import mbrs_pkg::*;
#(
   parameter int STACK_DEPTH = `MBRS_STACK_DEPTH,
   parameter int WDT_POST = `MBRS_WDT_POST
)
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   // Program memory
   output logic [20:0] PROG_ADDR,
   input wire logic [15:0] PROG_DATA,
   // Data register file
   output logic [11:0] DATA_ADDR,
   input wire logic [7:0] DATA_RDATA,
   output logic [7:0] DATA_WDATA,
   output logic DATA_WE,
   // Power control
   input wire logic WAKE_REQ,
   output logic OSC_RUN,
   output logic SLEEPING
);

   localparam int SPW = $clog2(STACK_DEPTH + 1);
   localparam int PW = $clog2(WDT_POST);

   typedef struct packed {
      logic run;
      logic wdt_en;
      logic [20:0] pc;
      logic [7:0] w;
      logic [3:0] bank_select_register;
      logic [4:0] flags;
      logic pd_n;
      logic to_n;
      logic sleeping;
      logic osc_run;
      mbrs_quarter_t q;
      logic hold_nop;
      logic [15:0] ir;
      logic [7:0] opnd;
      logic [11:0] data_addr;
      logic [7:0] data_wdata;
      logic data_we;
      logic [7:0] wdt;
      logic [PW-1:0] post;
      logic [SPW-1:0] sp;
      logic stk_full;
      logic [20:0] return_stack_top;
      logic [STACK_DEPTH-1:0][20:0] stack;
   } mbrs_core_t;

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic wake_s1;
      logic wake_s2;
   } mbrs_bus_t;

   typedef struct packed {
      mbrs_core_t core;
      mbrs_bus_t bus;
   } mbrs_state_t;

   mbrs_state_t st;
   mbrs_state_t next;
   mbrs_op_t op;
   logic [7:0] res;
   logic [8:0] diff;
   logic [4:0] nib;
   logic take;
   logic [20:0] ret_addr;

   function automatic mbrs_core_t core_reset();
      mbrs_core_t c;
      c = '0;
      c.run = `MBRS_RST_RUN;
      c.wdt_en = `MBRS_RST_WDT_EN;
      c.pc = `MBRS_RST_PC;
      c.w = `MBRS_RST_WREG;
      c.bank_select_register = `MBRS_RST_BANK;
      c.flags = `MBRS_RST_FLAGS;
      c.pd_n = 1'b1;
      c.to_n = 1'b1;
      c.osc_run = 1'b1;
      c.q = MBRS_Q1;
      c.ir = `MBRS_INSN_NOP;
      c.wdt = `MBRS_RST_WDT;
      return c;
   endfunction : core_reset

   function automatic mbrs_state_t state_reset();
      mbrs_state_t s;
      s = '0;
      s.core = core_reset();
      s.bus.hreadyout = 1'b1;
      return s;
   endfunction : state_reset

   function automatic mbrs_op_t decode(input logic [15:0] ir);
      mbrs_op_t o;
      o = MBRS_OP_NOP;
      if (ir[15:8] == `MBRS_OPC_BRANCH_CARRY)
         o = MBRS_OP_BRANCH_IF_CARRY;
      else if (ir[15:11] == `MBRS_OPC_REL_CALL)
         o = MBRS_OP_REL_SUB_CALL;
      else if (ir == `MBRS_INSN_RESET)
         o = MBRS_OP_SOFT_RESET;
      else if (ir == `MBRS_INSN_SLEEP)
         o = MBRS_OP_SLEEP;
      else if (ir[15:10] == `MBRS_OPC_ROT_LEFT)
         o = MBRS_OP_ROTATE_LEFT_NO_CARRY;
      else if (ir[15:10] == `MBRS_OPC_ROT_RIGHT)
         o = MBRS_OP_ROTATE_RIGHT_THRU_CARRY;
      else if (ir[15:10] == `MBRS_OPC_SUB_BORROW)
         o = MBRS_OP_SUB_F_FROM_W_BORROW;
      return o;
   endfunction : decode

   // Target of a relative jump: pc plus two plus twice the signed offset
   function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [20:0] off);
      return 21'(pc + `MBRS_PC_STEP + {off[19:0], 1'b0});
   endfunction : rel_target

   function automatic logic [11:0] file_addr(input logic [15:0] ir, input logic [3:0] bank_select_register);
      logic [11:0] a;
      a = {bank_select_register, ir[7:0]};
      if (!ir[8])
         a = {(ir[7] ? `MBRS_ACCESS_HIGH_BANK : `MBRS_ACCESS_LOW_BANK), ir[7:0]};
      return a;
   endfunction : file_addr

   function automatic logic [31:0] reg_read(input mbrs_state_t s, input logic [7:0] a);
      logic [31:0] r;
      r = '0;
      if (a == `MBRS_OFF_CTRL)
      begin
         r[`MBRS_CTRL_RUN] = s.core.run;
         r[`MBRS_CTRL_WDT_EN] = s.core.wdt_en;
      end
      else if (a == `MBRS_OFF_STATUS)
      begin
         r[`MBRS_FLAG_MSB:0] = s.core.flags;
         r[`MBRS_STAT_PD_N] = s.core.pd_n;
         r[`MBRS_STAT_TO_N] = s.core.to_n;
         r[`MBRS_STAT_SLEEP] = s.core.sleeping;
         r[`MBRS_STAT_STK_FULL] = s.core.stk_full;
      end
      else if (a == `MBRS_OFF_WREG)
         r[7:0] = s.core.w;
      else if (a == `MBRS_OFF_BANK)
         r[3:0] = s.core.bank_select_register;
      else if (a == `MBRS_OFF_PC)
         r[20:0] = s.core.pc;
      else if (a == `MBRS_OFF_TOS)
         r[20:0] = s.core.return_stack_top;
      else if (a == `MBRS_OFF_WDT)
         r[7:0] = s.core.wdt;
      else if (a == `MBRS_OFF_STKPTR)
         r[SPW-1:0] = s.core.sp;
      return r;
   endfunction : reg_read

   always_comb
   begin
      next = st;
      op = decode(st.core.ir);
      res = '0;
      diff = '0;
      nib = '0;
      take = 1'b0;
      ret_addr = 21'(st.core.pc + `MBRS_PC_STEP);
      next.core.data_we = 1'b0;
      next.bus.wake_s1 = WAKE_REQ;
      next.bus.wake_s2 = st.bus.wake_s1;

      // Bus data phase of a write
      if (st.bus.wr_pend)
      begin
         if (st.bus.wr_addr == `MBRS_OFF_CTRL)
         begin
            next.core.run = HWDATA[`MBRS_CTRL_RUN];
            next.core.wdt_en = HWDATA[`MBRS_CTRL_WDT_EN];
         end
         else if (st.bus.wr_addr == `MBRS_OFF_STATUS)
         begin
            next.core.flags = HWDATA[`MBRS_FLAG_MSB:0];
            if (HWDATA[`MBRS_STAT_STK_FULL])
               next.core.stk_full = 1'b0;
         end
         else if (st.bus.wr_addr == `MBRS_OFF_WREG)
            next.core.w = HWDATA[7:0];
         else if (st.bus.wr_addr == `MBRS_OFF_BANK)
            next.core.bank_select_register = HWDATA[3:0];
         else if (st.bus.wr_addr == `MBRS_OFF_PC)
            next.core.pc = {HWDATA[20:1], 1'b0};
      end

      // Bus address phase; read data is ready for the data phase
      next.bus.wr_pend = 1'b0;
      if (HSEL && HTRANS[1] && HREADY)
      begin
         next.bus.wr_pend = HWRITE;
         next.bus.wr_addr = HADDR[7:0];
         if (!HWRITE)
            next.bus.hrdata = reg_read(st, HADDR[7:0]);
      end

      // Watchdog postscaler and counter
      if (st.core.wdt_en)
      begin
         if (st.core.post == PW'(WDT_POST - 1))
         begin
            next.core.post = '0;
            next.core.wdt = 8'(st.core.wdt + 8'h01);
            if (st.core.wdt == 8'hFF && st.core.sleeping)
            begin
               next.core.to_n = 1'b0;
               next.core.sleeping = 1'b0;
               next.core.osc_run = 1'b1;
            end
         end
         else
            next.core.post = PW'(st.core.post + 1'b1);
      end
      if (st.bus.wake_s2 && st.core.sleeping)
      begin
         next.core.sleeping = 1'b0;
         next.core.osc_run = 1'b1;
      end

      if (st.core.run && !st.core.sleeping)
      begin
         case (st.core.q)
            MBRS_Q1:
            begin
               next.core.ir = st.core.hold_nop ? `MBRS_INSN_NOP : PROG_DATA;
               next.core.q = MBRS_Q2;
            end
            MBRS_Q2:
            begin
               next.core.data_addr = file_addr(st.core.ir, st.core.bank_select_register);
               if (op == MBRS_OP_REL_SUB_CALL)
               begin
                  if (st.core.sp < SPW'(STACK_DEPTH))
                  begin
                     next.core.stack[st.core.sp] = ret_addr;
                     next.core.sp = SPW'(st.core.sp + 1'b1);
                  end
                  else
                     next.core.stk_full = 1'b1;
                  next.core.return_stack_top = ret_addr;
               end
               next.core.q = MBRS_Q3;
            end
            MBRS_Q3:
            begin
               next.core.opnd = DATA_RDATA;
               next.core.q = MBRS_Q4;
            end
            default:
            begin
               next.core.q = MBRS_Q1;
               next.core.hold_nop = 1'b0;
               if (!st.core.hold_nop)
                  next.core.pc = ret_addr;
               case (op)
                  MBRS_OP_BRANCH_IF_CARRY:
                  begin
                     if (st.core.flags[`MBRS_FLAG_C])
                     begin
                        next.core.pc = rel_target(st.core.pc, 21'(signed'(st.core.ir[7:0])));
                        next.core.hold_nop = 1'b1;
                     end
                  end
                  MBRS_OP_REL_SUB_CALL:
                  begin
                     next.core.pc = rel_target(st.core.pc, 21'(signed'(st.core.ir[10:0])));
                     next.core.hold_nop = 1'b1;
                  end
                  MBRS_OP_SLEEP:
                  begin
                     next.core.wdt = `MBRS_RST_WDT;
                     next.core.post = '0;
                     next.core.pd_n = 1'b0;
                     next.core.to_n = 1'b1;
                     next.core.sleeping = 1'b1;
                     next.core.osc_run = 1'b0;
                  end
                  MBRS_OP_ROTATE_LEFT_NO_CARRY:
                  begin
                     res = {st.core.opnd[6:0], st.core.opnd[7]};
                     take = 1'b1;
                  end
                  MBRS_OP_ROTATE_RIGHT_THRU_CARRY:
                  begin
                     res = {st.core.flags[`MBRS_FLAG_C], st.core.opnd[7:1]};
                     next.core.flags[`MBRS_FLAG_C] = st.core.opnd[0];
                     take = 1'b1;
                  end
                  MBRS_OP_SUB_F_FROM_W_BORROW:
                  begin
                     diff = 9'({1'b0, st.core.w} - {1'b0, st.core.opnd}
                        - {8'h00, !st.core.flags[`MBRS_FLAG_C]});
                     nib = 5'({1'b0, st.core.w[3:0]} - {1'b0, st.core.opnd[3:0]}
                        - {4'h0, !st.core.flags[`MBRS_FLAG_C]});
                     res = diff[7:0];
                     next.core.flags[`MBRS_FLAG_C] = !diff[8];
                     next.core.flags[`MBRS_FLAG_DC] = !nib[4];
                     next.core.flags[`MBRS_FLAG_OV] = (st.core.w[7] ^ st.core.opnd[7])
                        & (st.core.w[7] ^ diff[7]);
                     take = 1'b1;
                  end
                  default:
                  begin
                     take = 1'b0;
                  end
               endcase
               if (take)
               begin
                  next.core.flags[`MBRS_FLAG_N] = res[7];
                  next.core.flags[`MBRS_FLAG_Z] = (res == 8'h00);
                  if (st.core.ir[9])
                  begin
                     next.core.data_wdata = res;
                     next.core.data_we = 1'b1;
                  end
                  else
                     next.core.w = res;
               end
            end
         endcase
         if (st.core.q == MBRS_Q2 && op == MBRS_OP_SOFT_RESET)
            next.core = core_reset();
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         st <= state_reset();
      else
         st <= next;
   end

   assign HREADYOUT = st.bus.hreadyout;
   assign HRDATA = st.bus.hrdata;
   assign HRESP = st.bus.hresp;
   assign PROG_ADDR = st.core.pc;
   assign DATA_ADDR = st.core.data_addr;
   assign DATA_WDATA = st.core.data_wdata;
   assign DATA_WE = st.core.data_we;
   assign OSC_RUN = st.core.osc_run;
   assign SLEEPING = st.core.sleeping;

endmodule : mbrs_exec
`default_nettype wire

// ---- bench/mbrs_mem_model.sv ----
// Program memory and data file model
`timescale 1ns/1ps
`default_nettype none
`include "mbrs_map.svh"
module mbrs_mem_model (
   // Clock
   input wire logic clk,
   // Program memory
   input wire logic [20:0] prog_addr,
   output logic [15:0] prog_data,
   // Data file
   input wire logic [11:0] data_addr,
   output logic [7:0] data_rdata,
   input wire logic [7:0] data_wdata,
   input wire logic data_we
);
   logic [15:0] pmem [4096];
   logic [7:0] dmem [4096];
   // Empty program space halts the core
   initial
   begin
      foreach (pmem[i]) pmem[i] = `MBRS_INSN_SLEEP;
      foreach (dmem[i]) dmem[i] = 8'h00;
   end
   assign prog_data = pmem[prog_addr[12:1]];
   assign data_rdata = dmem[data_addr];
   always @(posedge clk)
   begin
      if (data_we)
         dmem[data_addr] <= data_wdata;
   end
endmodule : mbrs_mem_model
`default_nettype wire

// ---- bench/mbrs_checker.sv ----
// Port assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
module mbrs_checker (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // Bus
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic [31:0] HRDATA,
   input wire logic HRESP,
   // Core
   input wire logic [20:0] PROG_ADDR,
   input wire logic [11:0] DATA_ADDR,
   input wire logic DATA_WE,
   input wire logic OSC_RUN,
   input wire logic SLEEPING
);
   logic wr_ph;
   logic rd_go;
   assign rd_go = HSEL && HTRANS[1] && HREADY && !HWRITE;
   always_ff @(posedge REF_CLK)
      wr_ph <= RST_N && HSEL && HTRANS[1] && HREADY && HWRITE;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_halted;
      SLEEPING && !OSC_RUN && !DATA_WE;
   endsequence
   sequence s_we_once;
      DATA_WE ##1 !DATA_WE [*3];
   endsequence
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not okay");
   a_sleep_halt: assert property (SLEEPING |-> s_halted)
      else $error("core active while asleep");
   a_pc_frozen: assert property (SLEEPING && $past(SLEEPING) && !$past(wr_ph)
      && !$past(wr_ph, 2) |-> $stable(PROG_ADDR))
      else $error("fetch address moved while asleep");
   a_we_once: assert property ($rose(DATA_WE) |-> s_we_once)
      else $error("file write not a single pulse");
   a_we_addr: assert property (DATA_WE |-> $stable(DATA_ADDR))
      else $error("file address moved during write");
   a_pc_even: assert property (PROG_ADDR[0] == 1'b0)
      else $error("odd fetch address");
   a_pc_hold: assert property ($changed(PROG_ADDR) && !SLEEPING && !$past(SLEEPING)
      |=> $stable(PROG_ADDR) [*3])
      else $error("fetch address held under four clocks");
   a_rdata_hold: assert property (!rd_go |=> $stable(HRDATA))
      else $error("read data changed without read");
endmodule : mbrs_checker
bind mbrs_exec mbrs_checker u_chk (.REF_CLK, .RST_N, .HSEL, .HTRANS, .HWRITE, .HREADY,
   .HREADYOUT, .HRDATA, .HRESP, .PROG_ADDR, .DATA_ADDR, .DATA_WE, .OSC_RUN, .SLEEPING);
`default_nettype wire

// ---- bench/mcu_branch_rotate_sleep_exec_tb.sv ----
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "mbrs_map.svh"
module mcu_branch_rotate_sleep_exec_tb;
   logic clk, rst_n, hsel, hwrite, wake, hrdy, hresp, we, osc, slp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [20:0] paddr;
   logic [15:0] pdata;
   logic [11:0] daddr, ad;
   logic [7:0] drd, dwd, w, v, f, n;
   logic [12:0] e;
   logic [10:0] m;
   logic [4:0] fl;
   logic [3:0] bk;
   logic d, a;
   logic [5:0] opc [3] = '{`MBRS_OPC_ROT_LEFT, `MBRS_OPC_ROT_RIGHT, `MBRS_OPC_SUB_BORROW};
   int bad_count, n_checks, base, cyc;
   mbrs_exec #(.WDT_POST(2)) DUT (.REF_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hrdy),
      .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp), .PROG_ADDR(paddr), .PROG_DATA(pdata),
      .DATA_ADDR(daddr), .DATA_RDATA(drd), .DATA_WDATA(dwd), .DATA_WE(we), .WAKE_REQ(wake),
      .OSC_RUN(osc), .SLEEPING(slp));
   mbrs_mem_model mem (.clk(clk), .prog_addr(paddr), .prog_data(pdata), .data_addr(daddr),
      .data_rdata(drd), .data_wdata(dwd), .data_we(we));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_cyc(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi)
      begin
         bad_count++;
         $display("MISMATCH t=%0t cycles %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_cyc
   task automatic bus(input logic wr, input logic [7:0] r, input logic [31:0] dt);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, r};
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= dt;
      do @(posedge clk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic rdchk(input logic [7:0] r, input logic [31:0] exp);
      bus(1'b0, r, 32'h0000_0000);
      chk(q, exp);
   endtask : rdchk
   task automatic wt(input logic lvl);
      while (slp !== lvl && cyc < 3000)
      begin
         @(posedge clk);
         cyc++;
      end
      // Limit reached counts as a failure
      if (slp !== lvl)
      begin
         bad_count++;
         $display("MISMATCH t=%0t sleep level %0b not reached", $time, lvl);
      end
   endtask : wt
   task automatic run();
      cyc = 0;
      @(posedge clk);
      wake <= 1'b1;
      wt(1'b0);
      wake <= 1'b0;
      wt(1'b1);
   endtask : run
   task automatic prep(input logic [15:0] ins, input logic [7:0] wv, input logic [4:0] fv,
         input logic [3:0] bv);
      mem.pmem[12'h800] = ins;
      bus(1'b1, `MBRS_OFF_WREG, {24'h00_0000, wv});
      bus(1'b1, `MBRS_OFF_STATUS, {27'h000_0000, fv});
      bus(1'b1, `MBRS_OFF_BANK, {28'h000_0000, bv});
      bus(1'b1, `MBRS_OFF_PC, 32'h0000_1000);
      run();
   endtask : prep
   function automatic logic [12:0] fop(input int k, input logic [7:0] wv, input logic [7:0] fv,
         input logic [4:0] fg);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      r = (k == 0) ? {fv[6:0], fv[7]} : {fg[0], fv[7:1]};
      if (k == 1) fg[0] = fv[0];
      if (k == 2)
      begin
         s = {1'b0, wv} + {1'b0, ~fv} + {8'h00, fg[0]};
         h = {1'b0, wv[3:0]} + {1'b0, ~fv[3:0]} + {4'h0, fg[0]};
         r = s[7:0];
         fg = {1'b0, (wv[7] != fv[7]) && (r[7] != wv[7]), 1'b0, h[4], s[8]};
      end
      return {r[7], fg[3], r == 8'h00, fg[1:0], r};
   endfunction : fop
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   initial
   begin
      {rst_n, hsel, hwrite, wake, htrans, haddr, hwdata} = '0;
      void'($urandom(51));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      cyc = 0;
      wt(1'b1);
      rdchk(`MBRS_OFF_STATUS, 32'h0000_0600);
      rdchk(`MBRS_OFF_PC, 32'h0000_0002);
      rdchk(8'h20, 32'h0000_0000);
      chk({31'h0000_0000, osc}, 32'h0000_0000);
      $display("test reset_sleep done");
      for (int i = 0; i < 15; i++)
      begin
         {d, a, bk, f, w, v} = 30'($urandom);
         fl = 5'($urandom);
         if (i < 2) {a, f} = i ? 9'h080 : 9'h07F;
         if (i == 2) v = w;
         ad = a ? {bk, f} : {{4{f[7]}}, f};
         mem.dmem[ad] = v;
         prep({opc[i % 3], d, a, f}, w, fl, bk);
         e = fop(i % 3, w, v, fl);
         if (i == 0) base = cyc;
         chk_cyc(cyc, base, base);
         rdchk(`MBRS_OFF_PC, 32'h0000_1004);
         rdchk(`MBRS_OFF_STATUS, 32'h0000_0600 | {27'h000_0000, e[12:8]});
         rdchk(`MBRS_OFF_WREG, {24'h00_0000, d ? w : e[7:0]});
         chk({24'h00_0000, mem.dmem[ad]}, {24'h00_0000, d ? e[7:0] : v});
      end
      $display("test file_ops done");
      for (int i = 0; i < 10; i++)
      begin
         n = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
         if (n == 8'hFF) n = 8'hFE;
         fl = 5'($urandom);
         prep({`MBRS_OPC_BRANCH_CARRY, n}, 8'h00, fl, 4'h0);
         rdchk(`MBRS_OFF_PC, fl[0] ? 32'h0000_1004 + {{23{n[7]}}, n, 1'b0} : 32'h0000_1004);
         chk_cyc(cyc, base + (fl[0] ? 4 : 0), base + (fl[0] ? 4 : 0));
      end
      $display("test branch done");
      for (int i = 0; i < 6; i++)
      begin
         m = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($urandom);
         if (m == 11'h7FF) m = 11'h7FE;
         prep({`MBRS_OPC_REL_CALL, m}, 8'h00, 5'h00, 4'h0);
         rdchk(`MBRS_OFF_PC, 32'h0000_1004 + {{20{m[10]}}, m, 1'b0});
         rdchk(`MBRS_OFF_TOS, 32'h0000_1002);
         chk_cyc(cyc, base + 4, base + 4);
      end
      $display("test call done");
      bus(1'b1, `MBRS_OFF_CTRL, 32'h0000_0003);
      prep(`MBRS_INSN_RESET, 8'h5A, 5'h1F, 4'h3);
      rdchk(`MBRS_OFF_PC, 32'h0000_0002);
      rdchk(`MBRS_OFF_WREG, 32'h0000_0000);
      rdchk(`MBRS_OFF_BANK, 32'h0000_0000);
      rdchk(`MBRS_OFF_CTRL, 32'h0000_0001);
      rdchk(`MBRS_OFF_STATUS, 32'h0000_0600);
      $display("test soft_reset done");
      mem.pmem[12'h800] = `MBRS_INSN_SLEEP;
      for (int j = 1; j < 5; j++) mem.pmem[12'h800 + j] = `MBRS_INSN_NOP;
      bus(1'b1, `MBRS_OFF_CTRL, 32'h0000_0003);
      repeat (200) @(posedge clk);
      bus(1'b1, `MBRS_OFF_PC, 32'h0000_1000);
      run();
      cyc = 0;
      wt(1'b0);
      chk_cyc(cyc, 500, 540);
      bus(1'b0, `MBRS_OFF_STATUS, 32'h0000_0000);
      chk({31'h0000_0000, q[9]}, 32'h0000_0000);
      wt(1'b1);
      rdchk(`MBRS_OFF_PC, 32'h0000_100C);
      rdchk(`MBRS_OFF_STATUS, 32'h0000_0600);
      bus(1'b1, `MBRS_OFF_CTRL, 32'h0000_0001);
      $display("test watchdog done");
      wrap_up();
   end
endmodule : mcu_branch_rotate_sleep_exec_tb
`default_nettype wire
